/* File: verilog/dbam_ctrl.sv */
// DRAM controller address translation, row management and port ordering
//
// Contract
// RL1 - Clock-enable pin keeps its last level while the device is suspended.
// RL2 - DDR3 reset pin keeps its last level during suspend.
// RL3 - Each port gives a flat byte address; row, bank, column derived inside.
// RL4 - Row and bank crossings inside a transfer are handled without port help.
// RL5 - Bit mapping follows build parameters for standard, width and density.
// RL6 - Four-bit parts: column bit 0 is zero, address bit 0 goes to column 1.
// RL7 - Eight-bit parts: byte address maps straight, bit 0 to column 0.
// RL8 - Sixteen-bit parts: address bit 1 goes to column bit 0.
// RL9 - Bank-interleaved or bank-high mapping, one chosen at build time.
// RL10 - Bank-high swaps bank and row fields; column layout unchanged.
// RL11 - Interleaved: end of row continues in same row of next bank.
// RL12 - Bank-high: crossing a row closes it and opens the next in that bank.
// RL13 - Within one port, commands run and complete in acceptance order.
// RL14 - Across ports, completion order need not follow request order.
// RL15 - Arbitration can favour one port; this does not force strict order.
// RL16 - Accepted writes may wait any time; other ports may see old data.
// RL17 - Port queue empty rises when its write starts; started writes finish.
// RL18 - User logic may confirm a write with a following dummy read.
// RL19 - User logic may raise the write port priority when no gaps occur.
// RL20 - Address bits above memory capacity do not affect row, bank, column.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module dbam_ctrl #(
   parameter dbam_pkg::dbam_mem_e   MEM_TYPE    = dbam_pkg::DBAM_DDR3,
   parameter dbam_pkg::dbam_width_e WIDTH       = dbam_pkg::DBAM_X16,
   parameter int                    COL_BITS    = 10,
   parameter int                    ROW_BITS    = 13,
   parameter int                    BANK_BITS   = 3,
   parameter int                    BANK_HIGH   = 0,
   parameter int                    NUM_PORTS   = 2,
   parameter int                    QUEUE_DEPTH = 4,
   parameter int                    STEP_BYTES  = 8
) (
   // Clock, reset, enable
   input  wire logic                  sys_clk,
   input  wire logic                  reset_n,
   input  wire logic                  clk_en,
   // Register port
   input  wire logic [3:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [31:0]                reg_rdata,
   // User command ports
   input  wire logic [NUM_PORTS-1:0]  up_valid,
   input  wire dbam_pkg::dbam_ucmd_s  up_cmd [NUM_PORTS],
   output logic [NUM_PORTS-1:0]       up_ready,
   output logic [NUM_PORTS-1:0]       up_empty,
   output logic [NUM_PORTS-1:0]       up_done,
   // Suspend pin
   input  wire logic                  suspend_pin,
   // Memory side
   output dbam_pkg::dbam_dcmd_s       dram_cmd,
   output logic                       dram_cke,
   output logic                       dram_reset_n
);
   // ***************************************
   // Local constants
   // ***************************************
   localparam int PW    = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
   localparam int NBANK = 1 << BANK_BITS;
   localparam logic [dbam_pkg::UADDR_W-1:0] STEP = dbam_pkg::UADDR_W'(STEP_BYTES);
   localparam logic [dbam_pkg::COL_W_MAX-1:0] COL_MASK =
      dbam_pkg::COL_W_MAX'((32'd1 << COL_BITS) - 32'd1);

   typedef enum logic [0:0] {ST_IDLE, ST_RUN} dbam_state_e;

   // ***************************************
   // Signals
   // ***************************************
   logic [31:0]                  ctrl_q;
   logic [31:0]                  rdata_d;
   logic                         susp_m_q;
   logic                         susp_s_q;
   dbam_state_e                  state_q;
   logic [PW-1:0]                cur_port_q;
   logic [PW-1:0]                rr_q;
   logic [PW-1:0]                sel;
   logic [dbam_pkg::UADDR_W-1:0] cur_addr_q;
   logic [dbam_pkg::LEN_W-1:0]   cur_left_q;
   logic                         cur_wr_q;
   logic [ROW_BITS-1:0]          open_row_q [NBANK];
   logic [NBANK-1:0]             open_vld_q;
   logic [NUM_PORTS-1:0]         pop;
   logic                         start;
   logic                         prio_en;
   logic [PW-1:0]                prio_port;
   dbam_pkg::dbam_ucmd_s         q_dout [NUM_PORTS];
   dbam_pkg::dbam_maddr_s        maddr;
   logic [BANK_BITS-1:0]         bsel;
   logic                         row_open;
   logic                         row_hit;
   logic                         do_col;
   logic                         do_pre;
   logic                         do_act;
   logic                         last_col;

   // ***************************************
   // Functions
   // ***************************************
   // First requesting port at or after the given start, wrapping round
   function automatic logic [PW-1:0] pick(input logic [NUM_PORTS-1:0] req,
                                          input logic [PW-1:0]        from);
      logic [PW-1:0] idx;
      logic          found;
      idx   = from;
      found = 1'b0;
      for (int i = 0; i < NUM_PORTS; i++) begin
         if (!found && req[(32'(from) + i) % NUM_PORTS]) begin
            idx   = PW'((32'(from) + i) % NUM_PORTS);
            found = 1'b1;
         end
      end
      return idx;
   endfunction

   function automatic logic [PW-1:0] after(input logic [PW-1:0] p);
      return (32'(p) == NUM_PORTS - 1) ? '0 : p + 1'b1;
   endfunction

   // ***************************************
   // Suspend pin synchroniser
   // ***************************************
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         susp_m_q <= 1'b0;
         susp_s_q <= 1'b0;
      end else if (clk_en) begin
         susp_m_q <= suspend_pin;
         susp_s_q <= susp_m_q;
      end
   end

   // ***************************************
   // Registers
   // ***************************************
   assign prio_en   = ctrl_q[dbam_pkg::CTRL_PRIO_EN_BIT];
   assign prio_port = PW'(ctrl_q[dbam_pkg::CTRL_PRIO_PORT_LSB +: dbam_pkg::CTRL_PRIO_PORT_W]);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ctrl_q <= dbam_pkg::CTRL_RESET;
      end else if (clk_en && reg_wr && reg_addr == dbam_pkg::REG_CTRL) begin
         ctrl_q <= reg_wdata;
      end
   end

   always_comb begin
      rdata_d = '0;
      unique case (reg_addr)
         dbam_pkg::REG_CTRL: rdata_d = ctrl_q;
         dbam_pkg::REG_STAT: begin
            rdata_d[dbam_pkg::STAT_BUSY_BIT] = state_q == ST_RUN;
            rdata_d[dbam_pkg::STAT_SUSP_BIT] = susp_s_q;
            for (int i = 0; i < NUM_PORTS && i < 8; i++) begin
               rdata_d[dbam_pkg::STAT_EMPTY_LSB + i] = up_empty[i];
            end
            for (int i = 0; i < NBANK && i < 16; i++) begin
               rdata_d[dbam_pkg::STAT_OPEN_LSB + i] = open_vld_q[i];
            end
         end
         dbam_pkg::REG_CFG: begin
            rdata_d[dbam_pkg::CFG_WIDTH_LSB +: 2] = WIDTH;
            rdata_d[dbam_pkg::CFG_TYPE_LSB +: 2]  = MEM_TYPE;
            rdata_d[dbam_pkg::CFG_BH_BIT]         = BANK_HIGH != 0; // RL9
            rdata_d[dbam_pkg::CFG_COL_LSB +: 8]   = 8'(COL_BITS);
            rdata_d[dbam_pkg::CFG_ROW_LSB +: 8]   = 8'(ROW_BITS);
            rdata_d[dbam_pkg::CFG_BANK_LSB +: 8]  = 8'(BANK_BITS);
         end
         default: rdata_d = '0;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? rdata_d : 32'h0000_0000;
      end
   end

   // ***************************************
   // Pin holding across suspend
   // ***************************************
   // The pin registers simply stop updating, so both pins keep the level they had when suspend arrived
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         dram_cke     <= 1'b0;
         dram_reset_n <= 1'b0;
      end else if (clk_en && !susp_s_q) begin
         dram_cke     <= ctrl_q[dbam_pkg::CTRL_CKE_BIT]; // RL1
         dram_reset_n <= (MEM_TYPE == dbam_pkg::DBAM_DDR3) ?
                         ctrl_q[dbam_pkg::CTRL_RST_BIT] : 1'b1; // RL2
      end
   end

   // ***************************************
   // Port queues
   // ***************************************
   for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
      dbam_cmd_queue #(
         .DEPTH   (QUEUE_DEPTH)
      ) u_queue (
         .sys_clk (sys_clk),
         .reset_n (reset_n),
         .clk_en  (clk_en),
         .push    (up_valid[g]),
         .din     (up_cmd[g]),
         .ready_q (up_ready[g]),
         .pop     (pop[g]),
         .dout    (q_dout[g]),
         .empty_q (up_empty[g])
      );
   end

   // ***************************************
   // Arbitration
   // ***************************************
   // Favoured port wins when it asks; otherwise round robin, so ports interleave
   always_comb begin
      sel   = pick(~up_empty, after(rr_q)); // RL14
      if (prio_en && !up_empty[prio_port]) sel = prio_port; // RL15
      start = state_q == ST_IDLE && !susp_s_q && |(~up_empty);
      pop   = '0;
      if (start) pop[sel] = 1'b1; // RL17
   end

   // ***************************************
   // Address translation
   // ***************************************
   dbam_addr_map #(
      .WIDTH     (WIDTH),
      .COL_BITS  (COL_BITS),
      .ROW_BITS  (ROW_BITS),
      .BANK_BITS (BANK_BITS),
      .BANK_HIGH (BANK_HIGH)
   ) u_map (
      .byte_addr (cur_addr_q),
      .maddr     (maddr)
   ); // RL3 RL5

   always_comb begin
      bsel     = maddr.bank[BANK_BITS-1:0];
      row_open = open_vld_q[bsel];
      row_hit  = row_open && open_row_q[bsel] == maddr.row[ROW_BITS-1:0];
      do_col   = state_q == ST_RUN && row_hit;
      do_pre   = state_q == ST_RUN && row_open && !row_hit; // RL12
      do_act   = state_q == ST_RUN && !row_open; // RL11
      last_col = do_col && cur_left_q == '0;
   end

   // ***************************************
   // Transfer engine
   // ***************************************
   // Once started a transfer always runs out, even if suspend arrives
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_q    <= ST_IDLE;
         cur_port_q <= '0;
         rr_q       <= PW'(NUM_PORTS - 1);
         cur_addr_q <= '0;
         cur_left_q <= '0;
         cur_wr_q   <= 1'b0;
      end else if (clk_en) begin
         unique case (state_q)
            ST_IDLE: begin
               if (start) begin
                  state_q    <= ST_RUN;
                  cur_port_q <= sel;
                  rr_q       <= sel;
                  cur_addr_q <= q_dout[sel].addr;
                  cur_left_q <= q_dout[sel].len;
                  cur_wr_q   <= q_dout[sel].write;
               end
            end
            ST_RUN: begin
               if (do_col) begin
                  cur_addr_q <= cur_addr_q + STEP; // RL4
                  cur_left_q <= cur_left_q - 1'b1;
                  if (last_col) state_q <= ST_IDLE; // RL13
               end
            end
         endcase
      end
   end

   // ***************************************
   // Open row tracking
   // ***************************************
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         open_vld_q <= '0;
      end else if (clk_en) begin
         if (do_pre) open_vld_q[bsel] <= 1'b0;
         if (do_act) open_vld_q[bsel] <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (clk_en && do_act) open_row_q[bsel] <= maddr.row[ROW_BITS-1:0];
   end

   // ***************************************
   // Memory command and completion
   // ***************************************
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         dram_cmd <= '{op: dbam_pkg::DBAM_NOP, default: '0};
         up_done  <= '0;
      end else if (clk_en) begin
         dram_cmd.row  <= maddr.row;
         dram_cmd.bank <= maddr.bank;
         dram_cmd.col  <= maddr.col;
         if (do_col) dram_cmd.op <= cur_wr_q ? dbam_pkg::DBAM_WR : dbam_pkg::DBAM_RD;
         else if (do_pre) dram_cmd.op <= dbam_pkg::DBAM_PRE;
         else if (do_act) dram_cmd.op <= dbam_pkg::DBAM_ACT;
         else dram_cmd.op <= dbam_pkg::DBAM_NOP;
         up_done <= '0;
         // A read done here proves every earlier write of that port is out
         if (last_col) up_done[cur_port_q] <= 1'b1; // RL13
      end
   end

   // ***************************************
   // Checks
   // ***************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   function automatic logic [dbam_pkg::COL_W_MAX-1:0] exp_col(input logic [dbam_pkg::UADDR_W-1:0] a);
      logic [dbam_pkg::UADDR_W-1:0] s;
      s = (WIDTH == dbam_pkg::DBAM_X4) ? (a << 1) : ((WIDTH == dbam_pkg::DBAM_X16) ? (a >> 1) : a);
      return s[dbam_pkg::COL_W_MAX-1:0] & COL_MASK;
   endfunction
   sequence s_pre_out;
      clk_en && dram_cmd.op == dbam_pkg::DBAM_PRE;
   endsequence
   sequence s_act_same;
      dram_cmd.op == dbam_pkg::DBAM_ACT && dram_cmd.bank == $past(dram_cmd.bank);
   endsequence
   a_cke_hold_susp: assert property (clk_en && susp_s_q |=> $stable(dram_cke)) // RL1
      else $error("clock enable pin moved during suspend");
   a_rst_hold_susp: assert property (clk_en && susp_s_q |=> $stable(dram_reset_n)) // RL2
      else $error("memory reset pin moved during suspend");
   a_x4_col_zero: assert property (WIDTH == dbam_pkg::DBAM_X4 && // RL6
      dram_cmd.op inside {dbam_pkg::DBAM_RD, dbam_pkg::DBAM_WR} |-> dram_cmd.col[0] == 1'b0)
      else $error("x4 column lsb not zero");
   a_col_map_ok: assert property (clk_en && do_col |=> // RL8
      dram_cmd.col == exp_col($past(cur_addr_q)))
      else $error("column field does not match byte address");
   a_row_hit_col: assert property (dram_cmd.op inside {dbam_pkg::DBAM_RD, dbam_pkg::DBAM_WR} |-> // RL4
      open_vld_q[dram_cmd.bank[BANK_BITS-1:0]] &&
      open_row_q[dram_cmd.bank[BANK_BITS-1:0]] == dram_cmd.row[ROW_BITS-1:0])
      else $error("column access to a row that is not open");
   a_pre_then_act: assert property (s_pre_out |=> s_act_same) // RL12
      else $error("precharge not followed by activate of same bank");
   a_prio_port_win: assert property (clk_en && start && prio_en && !up_empty[prio_port] |=> // RL15
      cur_port_q == prio_port)
      else $error("favoured port not chosen");
   a_susp_no_start: assert property (clk_en && susp_s_q && state_q == ST_IDLE |=> state_q == ST_IDLE) // RL1
      else $error("transfer started while suspended");
   a_done_in_order: assert property (clk_en && last_col |=> up_done == (NUM_PORTS'(1) << $past(cur_port_q))) // RL13
      else $error("completion not flagged for current port");
endmodule
`default_nettype wire

/* File: verilog/dbam_pkg.sv */
// Shared constants and types for the DRAM byte address mapping controller
package dbam_pkg;

   // ***************************************
   // Register map
   // ***************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_CFG  = 4'h8;

   localparam int CTRL_RST_BIT       = 0;
   localparam int CTRL_CKE_BIT       = 1;
   localparam int CTRL_PRIO_EN_BIT   = 2;
   localparam int CTRL_PRIO_PORT_LSB = 4;
   localparam int CTRL_PRIO_PORT_W   = 3;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_SUSP_BIT  = 1;
   localparam int STAT_EMPTY_LSB = 8;
   localparam int STAT_OPEN_LSB  = 16;

   localparam int CFG_WIDTH_LSB = 0;
   localparam int CFG_TYPE_LSB  = 2;
   localparam int CFG_BH_BIT    = 4;
   localparam int CFG_COL_LSB   = 8;
   localparam int CFG_ROW_LSB   = 16;
   localparam int CFG_BANK_LSB  = 24;

   // ***************************************
   // Address field limits
   // ***************************************
   localparam int UADDR_W   = 30;
   localparam int COL_W_MAX = 12;
   localparam int ROW_W_MAX = 16;
   localparam int BANK_W_MAX = 3;
   localparam int LEN_W     = 6;

   // ***************************************
   // Types
   // ***************************************
   typedef enum logic [1:0] {DBAM_X4, DBAM_X8, DBAM_X16} dbam_width_e;
   typedef enum logic [1:0] {DBAM_DDR, DBAM_DDR2, DBAM_DDR3, DBAM_LPDDR} dbam_mem_e;
   typedef enum logic [2:0] {DBAM_NOP, DBAM_ACT, DBAM_PRE, DBAM_RD, DBAM_WR} dbam_dop_e;

   typedef struct packed {
      logic               write;
      logic [UADDR_W-1:0] addr;
      logic [LEN_W-1:0]   len;
   } dbam_ucmd_s;

   typedef struct packed {
      logic [ROW_W_MAX-1:0]  row;
      logic [BANK_W_MAX-1:0] bank;
      logic [COL_W_MAX-1:0]  col;
   } dbam_maddr_s;

   typedef struct packed {
      dbam_dop_e             op;
      logic [ROW_W_MAX-1:0]  row;
      logic [BANK_W_MAX-1:0] bank;
      logic [COL_W_MAX-1:0]  col;
   } dbam_dcmd_s;

endpackage

/* File: verilog/dbam_addr_map.sv */
// Byte address to row, bank and column translation
`timescale 1ns/1ps
`default_nettype none
module dbam_addr_map #(
   parameter dbam_pkg::dbam_width_e WIDTH     = dbam_pkg::DBAM_X16,
   parameter int                    COL_BITS  = 10,
   parameter int                    ROW_BITS  = 13,
   parameter int                    BANK_BITS = 3,
   parameter int                    BANK_HIGH = 0
) (
   // User side
   input  wire logic [dbam_pkg::UADDR_W-1:0] byte_addr,
   // Memory side
   output dbam_pkg::dbam_maddr_s             maddr
);
   // ***************************************
   // Field layout
   // ***************************************
   localparam int SHIFT = (WIDTH == dbam_pkg::DBAM_X16) ? 1 : 0;
   localparam int UCB   = (WIDTH == dbam_pkg::DBAM_X4) ? COL_BITS - 1 : COL_BITS;
   localparam int BANK_BASE = (BANK_HIGH != 0) ? UCB + ROW_BITS : UCB;
   localparam int ROW_BASE  = (BANK_HIGH != 0) ? UCB : UCB + BANK_BITS;

   logic [dbam_pkg::UADDR_W-1:0] word;

   always_comb begin
      word  = byte_addr >> SHIFT; // RL8
      maddr = '0;
      for (int i = 0; i < dbam_pkg::COL_W_MAX; i++) begin
         if (i < COL_BITS) begin
            if (WIDTH == dbam_pkg::DBAM_X4) begin
               if (i > 0) maddr.col[i] = word[i-1]; // RL6
            end else begin
               maddr.col[i] = word[i]; // RL7
            end
         end
      end
      // Bits above the top field are never looked at
      for (int i = 0; i < dbam_pkg::BANK_W_MAX; i++) begin
         if (i < BANK_BITS) maddr.bank[i] = word[BANK_BASE+i]; // RL10
      end
      for (int i = 0; i < dbam_pkg::ROW_W_MAX; i++) begin
         if (i < ROW_BITS) maddr.row[i] = word[ROW_BASE+i]; // RL20
      end
   end
endmodule
`default_nettype wire

/* File: verilog/dbam_cmd_queue.sv */
// Per-port in-order command queue
`timescale 1ns/1ps
`default_nettype none
module dbam_cmd_queue #(
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   input  wire logic                 clk_en,
   // Fill side
   input  wire logic                 push,
   input  wire dbam_pkg::dbam_ucmd_s din,
   output logic                      ready_q,
   // Drain side
   input  wire logic                 pop,
   output dbam_pkg::dbam_ucmd_s      dout,
   output logic                      empty_q
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   dbam_pkg::dbam_ucmd_s mem_q [DEPTH];
   logic [AW-1:0]        wr_q;
   logic [AW-1:0]        rd_q;
   logic [AW:0]          cnt_q;
   logic [AW:0]          cnt_d;
   logic                 do_push;

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign do_push = push && ready_q;
   assign dout    = mem_q[rd_q];
   assign cnt_d   = cnt_q + (AW+1)'(do_push) - (AW+1)'(pop && !empty_q);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wr_q    <= '0;
         rd_q    <= '0;
         cnt_q   <= '0;
         ready_q <= 1'b1;
         empty_q <= 1'b1;
      end else if (clk_en) begin
         if (do_push) wr_q <= nxt(wr_q); // RL16
         if (pop && !empty_q) rd_q <= nxt(rd_q); // RL13
         cnt_q   <= cnt_d;
         ready_q <= cnt_d != FULL;
         empty_q <= cnt_d == '0; // RL17
      end
   end

   always_ff @(posedge sys_clk) begin
      if (clk_en && do_push) mem_q[wr_q] <= din;
   end

   a_empty_on_start: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL17
      clk_en && pop && !do_push && cnt_q == (AW+1)'(1) |=> empty_q)
      else $error("queue not empty after last command started");
endmodule
`default_nettype wire

/* File: testbench/dbam_dram_model.sv */
// Behavioural DRAM that tracks open rows and counts illegal commands
`timescale 1ns/1ps
`default_nettype none
module dbam_dram_model (
   // Clock and command
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   input  wire dbam_pkg::dbam_dcmd_s cmd,
   // Status
   output logic [7:0]                bad_cnt
);
   // ***************************************
   // Open row per bank
   // ***************************************
   logic [15:0] row_q [8];
   logic [7:0]  open_q;
   // A column access needs its row open; a second open without a close is illegal
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         open_q  <= 8'h00;
         bad_cnt <= 8'h00;
      end else if (cmd.op == dbam_pkg::DBAM_ACT) begin
         if (open_q[cmd.bank]) begin
            bad_cnt <= bad_cnt + 8'h01;
         end
         open_q[cmd.bank] <= 1'b1;
         row_q[cmd.bank]  <= cmd.row;
      end else if (cmd.op == dbam_pkg::DBAM_PRE) begin
         open_q[cmd.bank] <= 1'b0;
      end else if (cmd.op inside {dbam_pkg::DBAM_RD, dbam_pkg::DBAM_WR}) begin
         if (!open_q[cmd.bank] || row_q[cmd.bank] !== cmd.row) begin
            bad_cnt <= bad_cnt + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the address mapping controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
   // ***************************************
   // Stimulus and checks
   // ***************************************
   typedef struct {logic [29:0] a; logic w; logic [15:0] row; logic [2:0] bank; logic [11:0] col;} dbam_row_s;
   logic                 sys_clk = 1'b0;
   logic                 reset_n = 1'b0;
   logic                 suspend_pin = 1'b0;
   logic                 reg_wr = 1'b0;
   logic                 reg_rd = 1'b0;
   logic [3:0]           reg_addr = 4'h0;
   logic [31:0]          reg_wdata = 32'h0;
   logic [31:0]          reg_rdata;
   logic [1:0]           up_valid = 2'h0;
   logic [1:0]           up_ready, up_empty, up_done;
   dbam_pkg::dbam_ucmd_s up_cmd [2] = '{default: '0};
   dbam_pkg::dbam_dcmd_s dram_cmd;
   logic                 dram_cke, dram_reset_n;
   logic [7:0]           bad_cnt;
   int                   num_errors = 0;
   int                   n_tests = 0;
   // Upper three address bits in the last row lie above capacity
   dbam_row_s tbl [4] = '{'{30'h0, 1'b0, 16'h0, 3'h0, 12'h0}, '{30'h802, 1'b1, 16'h0, 3'h1, 12'h1},
                         '{30'h4006, 1'b0, 16'h1, 3'h0, 12'h3}, '{30'h3800_0000, 1'b0, 16'h0, 3'h0, 12'h0}};
   always #50 sys_clk = ~sys_clk;
   dbam_ctrl uut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .up_valid(up_valid),
      .up_cmd(up_cmd), .up_ready(up_ready), .up_empty(up_empty), .up_done(up_done),
      .suspend_pin(suspend_pin), .dram_cmd(dram_cmd), .dram_cke(dram_cke), .dram_reset_n(dram_reset_n));
   dbam_dram_model mem (.sys_clk(sys_clk), .reset_n(reset_n), .cmd(dram_cmd), .bad_cnt(bad_cnt));
   task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
   endtask
   task automatic send(input logic w, input logic [29:0] a, input logic [5:0] n);
      @(posedge sys_clk);
      up_valid[0] <= 1'b1;
      up_cmd[0] <= '{write: w, addr: a, len: n};
      @(posedge sys_clk);
      up_valid[0] <= 1'b0;
   endtask
   // Bounded wait for the next column command
   task automatic wait_col();
      for (int i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         #1;
         if (dram_cmd.op inside {dbam_pkg::DBAM_RD, dbam_pkg::DBAM_WR}) break;
      end
   endtask
   task automatic complete_run();
      `CHK("dram_protocol", 8'h00, bad_cnt)
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      `CHK("rst_empty", 2'b11, up_empty)
      `CHK("rst_cke", 1'b0, dram_cke)
      reset_n <= 1'b1;
      reg_acc(1'b0, dbam_pkg::REG_CFG, 32'h0);
      `CHK("cfg", 32'h030d_0a0a, reg_rdata)
      reg_acc(1'b0, 4'hc, 32'h0);
      `CHK("unmapped", 32'h0, reg_rdata)
      foreach (tbl[i]) begin
         send(tbl[i].w, tbl[i].a, 6'h00);
         wait_col();
         `CHK("op", tbl[i].w ? dbam_pkg::DBAM_WR : dbam_pkg::DBAM_RD, dram_cmd.op)
         `CHK("row", tbl[i].row, dram_cmd.row)
         `CHK("bank", tbl[i].bank, dram_cmd.bank)
         `CHK("col", tbl[i].col, dram_cmd.col)
         `CHK("done", 1'b1, up_done[0])
      end
      // Last column of a row, then the same row of the next bank
      send(1'b0, 30'h7fe, 6'h01);
      wait_col();
      `CHK("end_col", 12'h3ff, dram_cmd.col)
      wait_col();
      `CHK("next_bank", 3'h1, dram_cmd.bank)
      `CHK("next_col", 12'h003, dram_cmd.col)
      `CHK("last_done", 1'b1, up_done[0])
      `CHK("empty", 1'b1, up_empty[0])
      reg_acc(1'b1, dbam_pkg::REG_CTRL, 32'h3);
      @(posedge sys_clk);
      suspend_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reg_acc(1'b1, dbam_pkg::REG_CTRL, 32'h0);
      send(1'b0, 30'h0, 6'h00);
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK("susp_cke", 1'b1, dram_cke)
      `CHK("susp_rst", 1'b1, dram_reset_n)
      `CHK("susp_hold", 1'b0, up_empty[0])
      `CHK("susp_ready", 1'b1, up_ready[0])
      reg_acc(1'b0, dbam_pkg::REG_STAT, 32'h0);
      `CHK("stat", 32'h0003_0202, reg_rdata)
      @(posedge sys_clk);
      suspend_pin <= 1'b0;
      wait_col();
      `CHK("resume_op", dbam_pkg::DBAM_RD, dram_cmd.op)
      `CHK("resume_cke", 1'b0, dram_cke)
      `CHK("resume_rst", 1'b0, dram_reset_n)
      // Favoured port 0 writes while port 1 reads the same word
      reg_acc(1'b1, dbam_pkg::REG_CTRL, 32'h4);
      @(posedge sys_clk);
      up_valid <= 2'b11;
      up_cmd <= '{'{1'b1, 30'h10, 6'h00}, '{1'b0, 30'h10, 6'h00}};
      @(posedge sys_clk);
      up_valid <= 2'b00;
      wait_col();
      `CHK("prio_op", dbam_pkg::DBAM_WR, dram_cmd.op)
      `CHK("prio_done", 2'b01, up_done)
      wait_col();
      `CHK("other_op", dbam_pkg::DBAM_RD, dram_cmd.op)
      `CHK("other_done", 2'b10, up_done)
      complete_run();
   end
   initial begin
      #500000;
      num_errors++;
      complete_run();
   end
endmodule
`default_nettype wire
